// file: rtl/sleep_wake_pkg.sv
// Shared constants for the sleep, wake-up and external interrupt sense controller.
// Assumes a single 10 MHz system clock and the plain register port described in the top module.
package sleep_wake_pkg;

    // Register word addresses on the plain register port
    localparam logic [7:0] ADDR_SLEEP_IRQ_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_EXT_IRQ_MASK = 8'h01;
    localparam logic [7:0] ADDR_WAKE_STATUS = 8'h02;

    // Control register field positions
    localparam int unsigned PIN_ZERO_SENSE_LO = 0;
    localparam int unsigned PIN_ZERO_SENSE_HI = 1;
    localparam int unsigned PIN_ONE_SENSE_LO = 2;
    localparam int unsigned PIN_ONE_SENSE_HI = 3;
    localparam int unsigned DOZE_KIND_LO = 4;
    localparam int unsigned DOZE_KIND_HI = 5;
    localparam int unsigned DOZE_PERMIT = 6;
    localparam logic [7:0] CONTROL_WRITE_MASK = 8'h7f;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // Mask register field positions
    localparam int unsigned MASK_PIN_ZERO = 0;
    localparam int unsigned MASK_PIN_ONE = 1;
    localparam logic [7:0] MASK_WRITE_MASK = 8'h03;
    localparam logic [7:0] MASK_RESET = 8'h00;

    // Status register field positions
    localparam int unsigned STAT_ASLEEP = 0;
    localparam int unsigned STAT_STARTUP = 1;
    localparam int unsigned STAT_KIND_LO = 2;
    localparam int unsigned STAT_PIN_ZERO = 4;
    localparam int unsigned STAT_PIN_ONE = 5;
    localparam int unsigned STAT_FLAG_ZERO = 6;
    localparam int unsigned STAT_FLAG_ONE = 7;

    // Sense field codes
    localparam logic [1:0] SENSE_LOW_LEVEL = 2'h0;
    localparam logic [1:0] SENSE_RESERVED = 2'h1;
    localparam logic [1:0] SENSE_FALLING = 2'h2;
    localparam logic [1:0] SENSE_RISING = 2'h3;

    // Sleep mode codes
    localparam logic [1:0] KIND_IDLE = 2'h0;
    localparam logic [1:0] KIND_RESERVED = 2'h1;
    localparam logic [1:0] KIND_POWER_DOWN = 2'h2;
    localparam logic [1:0] KIND_POWER_SAVE = 2'h3;

    // Oscillator start-up delay after a deep-sleep wake-up
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned RESET_DELAY_TIMEOUT_NS = 16000;
    localparam int unsigned RESET_DELAY_CYCLES_RAW = (RESET_DELAY_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RESET_DELAY_CYCLES = (RESET_DELAY_CYCLES_RAW < 1) ? 1 : RESET_DELAY_CYCLES_RAW;
    localparam int unsigned DELAY_W = 12;
    localparam logic [DELAY_W-1:0] DELAY_LAST = DELAY_W'(RESET_DELAY_CYCLES - 1);
    localparam logic [DELAY_W-1:0] DELAY_ZERO = 12'h000;
    localparam logic [DELAY_W-1:0] DELAY_ONE = 12'h001;

    // Controller states, one-hot
    typedef enum logic [4:0] {
        ST_AWAKE = 5'b00001,
        ST_IDLE = 5'b00010,
        ST_POWER_DOWN = 5'b00100,
        ST_POWER_SAVE = 5'b01000,
        ST_STARTUP = 5'b10000
    } sleep_state_t;

endpackage : sleep_wake_pkg

// file: rtl/sleep_wake_ext_irq_ctrl.sv
// Sleep-mode entry, wake-up decision and external interrupt pin sense control.
// Assumes the core gives a one-cycle sleep pulse, the global enable flag as a level, and
// acknowledges each taken external interrupt with a one-cycle pulse. Pins arrive asynchronously.
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps

module sleep_wake_ext_irq_ctrl (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // External interrupt pins, asynchronous
    input wire logic ext_irq_pin_zero,
    input wire logic ext_irq_pin_one,
    // Core side
    input wire logic sleep_instr,
    input wire logic global_irq_en,
    input wire logic irq_ack_zero,
    input wire logic irq_ack_one,
    output logic ext_irq_req_zero,
    output logic ext_irq_req_one,
    // Other wake sources
    input wire logic ext_reset_pin_n,
    input wire logic internal_irq_req,
    input wire logic wdt_enable,
    input wire logic wdt_timeout,
    input wire logic timer_two_async_sel,
    input wire logic timer_two_ovf_irq,
    input wire logic timer_two_cmp_irq,
    // Power control
    output logic cpu_halt,
    output logic main_osc_stop,
    output logic sync_timers_run,
    output logic timer_two_run,
    output logic wake_resume,
    output logic reset_vector_req
);

    sleep_wake_pkg::sleep_state_t state;
    sleep_wake_pkg::sleep_state_t next_state;
    sleep_wake_pkg::sleep_state_t resume_state;

    logic [7:0] mcu_sleep_irq_control;
    logic [7:0] ext_irq_mask_reg;
    logic [sleep_wake_pkg::DELAY_W-1:0] delay_count;
    logic level_wake;

    logic [1:0] pin_zero_meta;
    logic [1:0] pin_one_meta;
    logic [1:0] rst_meta;
    logic pin_zero_sync;
    logic pin_one_sync;
    logic pin_zero_prev;
    logic pin_one_prev;
    logic ext_reset_sync_n;

    logic flag_zero;
    logic flag_one;
    logic level_zero;
    logic level_one;
    logic edge_zero;
    logic edge_one;
    logic enable_zero;
    logic enable_one;
    logic clock_running;
    logic enabled_level_req;
    logic idle_wake;
    logic deep_wake;
    logic save_wake;

    // Sense decode shared by both pins: level, falling or rising; reserved code gives nothing
    function automatic logic sense_hit(input logic [1:0] code, input logic cur, input logic prev,
                                       input logic want_level);
        logic hit;
        hit = 1'b0;
        case (code)
            sleep_wake_pkg::SENSE_LOW_LEVEL: hit = want_level & ~cur;
            sleep_wake_pkg::SENSE_FALLING: hit = ~want_level & prev & ~cur;
            sleep_wake_pkg::SENSE_RISING: hit = ~want_level & ~prev & cur;
            sleep_wake_pkg::SENSE_RESERVED: hit = 1'b0;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : sense_hit

    // Write decode used by every writable register
    function automatic logic write_hit(input logic wr, input logic [7:0] addr, input logic [7:0] target);
        return wr & (addr == target);
    endfunction : write_hit

    // Two-stage synchronisers for the pins; the first stage feeds only the second
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_zero_meta <= 2'h3;
            pin_one_meta <= 2'h3;
            rst_meta <= 2'h3;
        end else begin
            pin_zero_meta <= {pin_zero_meta[0], ext_irq_pin_zero};
            pin_one_meta <= {pin_one_meta[0], ext_irq_pin_one};
            rst_meta <= {rst_meta[0], ext_reset_pin_n};
        end
    end

    assign pin_zero_sync = pin_zero_meta[1];
    assign pin_one_sync = pin_one_meta[1];
    assign ext_reset_sync_n = rst_meta[1];

    // Previous synchronised sample for edge comparison
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_zero_prev <= 1'b1;
            pin_one_prev <= 1'b1;
        end else begin
            pin_zero_prev <= pin_zero_sync;
            pin_one_prev <= pin_one_sync;
        end
    end

    // Sense field decode per pin
    assign level_zero = sense_hit(mcu_sleep_irq_control[sleep_wake_pkg::PIN_ZERO_SENSE_HI:
                                  sleep_wake_pkg::PIN_ZERO_SENSE_LO], pin_zero_sync, pin_zero_prev, 1'b1);
    assign edge_zero = sense_hit(mcu_sleep_irq_control[sleep_wake_pkg::PIN_ZERO_SENSE_HI:
                                 sleep_wake_pkg::PIN_ZERO_SENSE_LO], pin_zero_sync, pin_zero_prev, 1'b0);
    assign level_one = sense_hit(mcu_sleep_irq_control[sleep_wake_pkg::PIN_ONE_SENSE_HI:
                                 sleep_wake_pkg::PIN_ONE_SENSE_LO], pin_one_sync, pin_one_prev, 1'b1);
    assign edge_one = sense_hit(mcu_sleep_irq_control[sleep_wake_pkg::PIN_ONE_SENSE_HI:
                                sleep_wake_pkg::PIN_ONE_SENSE_LO], pin_one_sync, pin_one_prev, 1'b0);

    // The system clock is modelled as stopped in the deep sleep modes, so edges there are lost
    assign clock_running = (state == sleep_wake_pkg::ST_AWAKE) || (state == sleep_wake_pkg::ST_IDLE);

    // Edge events latch until the core acknowledges; a new edge beats a same-cycle acknowledge
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flag_zero <= 1'b0;
        end else if (edge_zero && clock_running) begin
            flag_zero <= 1'b1;
        end else if (irq_ack_zero) begin
            flag_zero <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flag_one <= 1'b0;
        end else if (edge_one && clock_running) begin
            flag_one <= 1'b1;
        end else if (irq_ack_one) begin
            flag_one <= 1'b0;
        end
    end

    // Requests reach the core only with the global flag and the pin's mask bit set
    assign enable_zero = global_irq_en & ext_irq_mask_reg[sleep_wake_pkg::MASK_PIN_ZERO];
    assign enable_one = global_irq_en & ext_irq_mask_reg[sleep_wake_pkg::MASK_PIN_ONE];
    assign ext_irq_req_zero = enable_zero & (flag_zero | level_zero) & clock_running;
    assign ext_irq_req_one = enable_one & (flag_one | level_one) & clock_running;

    // Wake conditions per mode
    assign enabled_level_req = (enable_zero & level_zero) | (enable_one & level_one);
    assign idle_wake = ext_irq_req_zero | ext_irq_req_one | internal_irq_req | wdt_timeout;
    assign deep_wake = enabled_level_req | (wdt_enable & wdt_timeout);
    assign save_wake = deep_wake | (timer_two_async_sel & (timer_two_ovf_irq | timer_two_cmp_irq));

    // Control register: sense fields, mode field and sleep permit; bit 7 reads zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mcu_sleep_irq_control <= sleep_wake_pkg::CONTROL_RESET;
        end else if (write_hit(reg_wr, reg_addr, sleep_wake_pkg::ADDR_SLEEP_IRQ_CONTROL)) begin
            mcu_sleep_irq_control <= reg_wdata & sleep_wake_pkg::CONTROL_WRITE_MASK;
        end
    end

    // Mask register for the two pins
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ext_irq_mask_reg <= sleep_wake_pkg::MASK_RESET;
        end else if (write_hit(reg_wr, reg_addr, sleep_wake_pkg::ADDR_EXT_IRQ_MASK)) begin
            ext_irq_mask_reg <= reg_wdata & sleep_wake_pkg::MASK_WRITE_MASK;
        end
    end

    // Next-state decision
    always_comb begin
        next_state = state;
        case (state)
            sleep_wake_pkg::ST_AWAKE: begin
                if (sleep_instr && mcu_sleep_irq_control[sleep_wake_pkg::DOZE_PERMIT]) begin
                    case (mcu_sleep_irq_control[sleep_wake_pkg::DOZE_KIND_HI:sleep_wake_pkg::DOZE_KIND_LO])
                        sleep_wake_pkg::KIND_IDLE: next_state = sleep_wake_pkg::ST_IDLE;
                        sleep_wake_pkg::KIND_POWER_DOWN: next_state = sleep_wake_pkg::ST_POWER_DOWN;
                        sleep_wake_pkg::KIND_POWER_SAVE: next_state = sleep_wake_pkg::ST_POWER_SAVE;
                        default: next_state = sleep_wake_pkg::ST_AWAKE;
                    endcase
                end
            end
            sleep_wake_pkg::ST_IDLE: begin
                if (idle_wake) begin
                    next_state = sleep_wake_pkg::ST_AWAKE;
                end
            end
            sleep_wake_pkg::ST_POWER_DOWN: begin
                if (deep_wake) begin
                    next_state = sleep_wake_pkg::ST_STARTUP;
                end
            end
            sleep_wake_pkg::ST_POWER_SAVE: begin
                if (save_wake) begin
                    next_state = sleep_wake_pkg::ST_STARTUP;
                end
            end
            sleep_wake_pkg::ST_STARTUP: begin
                if (level_wake && !enabled_level_req) begin
                    next_state = resume_state;
                end else if (delay_count == sleep_wake_pkg::DELAY_ZERO) begin
                    next_state = sleep_wake_pkg::ST_AWAKE;
                end
            end
            default: next_state = sleep_wake_pkg::ST_AWAKE;
        endcase
        if (!ext_reset_sync_n) begin
            next_state = sleep_wake_pkg::ST_AWAKE;
        end
    end

    // State register; wake-up never touches core storage, only this controller's own state
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= sleep_wake_pkg::ST_AWAKE;
        end else begin
            state <= next_state;
        end
    end

    // Remember which deep mode to return to if a level request falls away during start-up
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            resume_state <= sleep_wake_pkg::ST_POWER_DOWN;
            level_wake <= 1'b0;
        end else if ((state == sleep_wake_pkg::ST_POWER_DOWN || state == sleep_wake_pkg::ST_POWER_SAVE)
                     && next_state == sleep_wake_pkg::ST_STARTUP) begin
            resume_state <= state;
            level_wake <= enabled_level_req & ~(wdt_enable & wdt_timeout);
        end
    end

    // Oscillator start-up delay counter
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            delay_count <= sleep_wake_pkg::DELAY_LAST;
        end else if (state != sleep_wake_pkg::ST_STARTUP) begin
            delay_count <= sleep_wake_pkg::DELAY_LAST;
        end else if (delay_count != sleep_wake_pkg::DELAY_ZERO) begin
            delay_count <= delay_count - sleep_wake_pkg::DELAY_ONE;
        end
    end

    // Power control outputs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cpu_halt <= 1'b0;
            main_osc_stop <= 1'b0;
            sync_timers_run <= 1'b1;
            timer_two_run <= 1'b1;
        end else begin
            cpu_halt <= (next_state != sleep_wake_pkg::ST_AWAKE);
            main_osc_stop <= (next_state == sleep_wake_pkg::ST_POWER_DOWN)
                             || (next_state == sleep_wake_pkg::ST_POWER_SAVE);
            sync_timers_run <= (next_state == sleep_wake_pkg::ST_AWAKE)
                               || (next_state == sleep_wake_pkg::ST_IDLE);
            timer_two_run <= (next_state == sleep_wake_pkg::ST_AWAKE)
                             || (next_state == sleep_wake_pkg::ST_IDLE)
                             || ((next_state == sleep_wake_pkg::ST_POWER_SAVE)
                                 && timer_two_async_sel);
        end
    end

    // Wake and reset-vector pulses to the core
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wake_resume <= 1'b0;
            reset_vector_req <= 1'b0;
        end else begin
            wake_resume <= (state != sleep_wake_pkg::ST_AWAKE) && (next_state == sleep_wake_pkg::ST_AWAKE)
                           && ext_reset_sync_n;
            reset_vector_req <= (state != sleep_wake_pkg::ST_AWAKE) && !ext_reset_sync_n;
        end
    end

    // Read data, valid in the cycle after the read strobe; unmapped addresses read zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                sleep_wake_pkg::ADDR_SLEEP_IRQ_CONTROL: reg_rdata <= mcu_sleep_irq_control;
                sleep_wake_pkg::ADDR_EXT_IRQ_MASK: reg_rdata <= ext_irq_mask_reg;
                sleep_wake_pkg::ADDR_WAKE_STATUS: begin
                    reg_rdata <= 8'h00;
                    reg_rdata[sleep_wake_pkg::STAT_ASLEEP] <= (state != sleep_wake_pkg::ST_AWAKE);
                    reg_rdata[sleep_wake_pkg::STAT_STARTUP] <= (state == sleep_wake_pkg::ST_STARTUP);
                    reg_rdata[sleep_wake_pkg::STAT_KIND_LO +: 2] <=
                        mcu_sleep_irq_control[sleep_wake_pkg::DOZE_KIND_HI:sleep_wake_pkg::DOZE_KIND_LO];
                    reg_rdata[sleep_wake_pkg::STAT_PIN_ZERO] <= pin_zero_sync;
                    reg_rdata[sleep_wake_pkg::STAT_PIN_ONE] <= pin_one_sync;
                    reg_rdata[sleep_wake_pkg::STAT_FLAG_ZERO] <= flag_zero;
                    reg_rdata[sleep_wake_pkg::STAT_FLAG_ONE] <= flag_one;
                end
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule : sleep_wake_ext_irq_ctrl

// file: verification/sleep_wake_monitor.sv
// Port-level checker for the sleep, wake and external interrupt controller.
// Assumes one clock, synchronous active-low reset; shadows the writable registers.
`timescale 1ns/1ps
module sleep_wake_monitor (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    // Core and wake sources
    input wire logic sleep_instr,
    input wire logic global_irq_en,
    input wire logic ext_reset_pin_n,
    input wire logic internal_irq_req,
    input wire logic wdt_enable,
    input wire logic wdt_timeout,
    input wire logic timer_two_async_sel,
    // Outputs
    input wire logic ext_irq_req_zero,
    input wire logic ext_irq_req_one,
    input wire logic cpu_halt,
    input wire logic main_osc_stop,
    input wire logic sync_timers_run,
    input wire logic timer_two_run,
    input wire logic wake_resume,
    input wire logic reset_vector_req
);
    logic [7:0] ctl;
    logic [7:0] msk;
    logic go;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctl <= 8'h00;
            msk <= 8'h00;
        end else if (reg_wr && reg_addr == 8'h00) begin
            ctl <= reg_wdata & 8'h7f;
        end else if (reg_wr && reg_addr == 8'h01) begin
            msk <= reg_wdata & 8'h03;
        end
    end
    // Sleep request seen while awake with permit set
    assign go = sleep_instr && !cpu_halt && ctl[6];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    AST_SLEEP_GO: assert property (go && ctl[5:4] != 2'h1 |=> cpu_halt) else $error("sleep not entered");
    AST_SLEEP_OFF: assert property (sleep_instr && !cpu_halt && !ctl[6] |=> !cpu_halt)
        else $error("sleep without permit");
    AST_IDLE_KEEPS: assert property (go && ctl[5:4] == 2'h0 |=> cpu_halt && sync_timers_run
        && !main_osc_stop) else $error("idle stopped too much");
    AST_DEEP_STOPS: assert property (go && ctl[5] |=> main_osc_stop && !sync_timers_run)
        else $error("deep sleep kept clock");
    AST_IDLE_WAKE: assert property (cpu_halt && sync_timers_run && internal_irq_req && ext_reset_pin_n
        |=> !cpu_halt && wake_resume) else $error("idle wake late");
    AST_EDGE_NO_WAKE: assert property (main_osc_stop && ctl[1] && ctl[3] && !wdt_enable
        && !timer_two_async_sel && ext_reset_pin_n && $past(ext_reset_pin_n) && $past(ext_reset_pin_n, 2)
        |=> main_osc_stop) else $error("deep sleep left on edge");
    AST_WDT_WAKE: assert property (main_osc_stop && wdt_enable && wdt_timeout |=> !main_osc_stop)
        else $error("watchdog did not wake");
    AST_T2_KEEPS: assert property (main_osc_stop && ctl[5:4] == 2'h3 && timer_two_async_sel
        && $past(timer_two_async_sel) |-> timer_two_run) else $error("timer two halted");
    AST_REQ_GATE: assert property ((ext_irq_req_zero || ext_irq_req_one) |-> global_irq_en
        && (msk[0] || !ext_irq_req_zero) && (msk[1] || !ext_irq_req_one)) else $error("request not gated");
    AST_RESERVED: assert property (ctl[1:0] == 2'h1 |-> !ext_irq_req_zero) else $error("reserved fired");
    AST_RESET_VEC: assert property (reset_vector_req |-> !cpu_halt && !wake_resume)
        else $error("reset wake wrong");
endmodule : sleep_wake_monitor

bind sleep_wake_ext_irq_ctrl sleep_wake_monitor mon_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .sleep_instr(sleep_instr), .global_irq_en(global_irq_en),
    .ext_reset_pin_n(ext_reset_pin_n), .internal_irq_req(internal_irq_req), .wdt_enable(wdt_enable),
    .wdt_timeout(wdt_timeout), .timer_two_async_sel(timer_two_async_sel), .ext_irq_req_zero(ext_irq_req_zero),
    .ext_irq_req_one(ext_irq_req_one), .cpu_halt(cpu_halt), .main_osc_stop(main_osc_stop),
    .sync_timers_run(sync_timers_run), .timer_two_run(timer_two_run), .wake_resume(wake_resume),
    .reset_vector_req(reset_vector_req));

// file: verification/core_ack_model.sv
// Core stand-in that takes external interrupt requests.
// Assumes requests are levels; acknowledges only while told to.
`timescale 1ns/1ps
module core_ack_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control and requests
    input wire logic auto_ack,
    input wire logic ext_irq_req_zero,
    input wire logic ext_irq_req_one,
    // Acknowledge pulses
    output logic irq_ack_zero,
    output logic irq_ack_one
);
    // One-cycle acknowledge with a gap before the next
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_ack_zero <= 1'h0;
            irq_ack_one <= 1'h0;
        end else begin
            irq_ack_zero <= auto_ack && ext_irq_req_zero && !irq_ack_zero;
            irq_ack_one <= auto_ack && ext_irq_req_one && !irq_ack_one;
        end
    end
endmodule : core_ack_model

// file: verification/tb.sv
// Self-checking bench for the sleep, wake and external interrupt controller.
// Assumes the design package, design, checker and core model are compiled first.
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, sleep_instr = 1'h0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d, v;
    logic global_irq_en = 1'h0, auto_ack = 1'h0, internal_irq_req = 1'h0, wdt_enable = 1'h0, wdt_timeout = 1'h0;
    logic timer_two_async_sel = 1'h0, timer_two_ovf_irq = 1'h0, timer_two_cmp_irq = 1'h0;
    logic ext_irq_pin_zero = 1'h1, ext_irq_pin_one = 1'h1, ext_reset_pin_n = 1'h1;
    logic irq_ack_zero, irq_ack_one, ext_irq_req_zero, ext_irq_req_one, cpu_halt, main_osc_stop;
    logic sync_timers_run, timer_two_run, wake_resume, reset_vector_req;
    int err_count = 0, samples_checked = 0, vecs = 0;
    sleep_wake_ext_irq_ctrl dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq_pin_zero(ext_irq_pin_zero),
        .ext_irq_pin_one(ext_irq_pin_one), .sleep_instr(sleep_instr), .global_irq_en(global_irq_en),
        .irq_ack_zero(irq_ack_zero), .irq_ack_one(irq_ack_one), .ext_irq_req_zero(ext_irq_req_zero),
        .ext_irq_req_one(ext_irq_req_one), .ext_reset_pin_n(ext_reset_pin_n), .internal_irq_req(internal_irq_req),
        .wdt_enable(wdt_enable), .wdt_timeout(wdt_timeout), .timer_two_async_sel(timer_two_async_sel),
        .timer_two_ovf_irq(timer_two_ovf_irq), .timer_two_cmp_irq(timer_two_cmp_irq), .cpu_halt(cpu_halt),
        .main_osc_stop(main_osc_stop), .sync_timers_run(sync_timers_run), .timer_two_run(timer_two_run),
        .wake_resume(wake_resume), .reset_vector_req(reset_vector_req));
    core_ack_model model_u (.ref_clk(ref_clk), .rst_n(rst_n), .auto_ack(auto_ack),
        .ext_irq_req_zero(ext_irq_req_zero), .ext_irq_req_one(ext_irq_req_one),
        .irq_ack_zero(irq_ack_zero), .irq_ack_one(irq_ack_one));
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (reset_vector_req === 1'h1) vecs++;
    end
    function automatic logic fall_req(int c);
        return c == 0 || c == 2;
    endfunction : fall_req
    function automatic logic req_of(int p);
        return p ? ext_irq_req_one : ext_irq_req_zero;
    endfunction : req_of
    task automatic print_verdict;
        if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cyc(int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    task automatic wr(logic [7:0] a, logic [7:0] w);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'h1;
        cyc(1);
        reg_wr <= 1'h0;
        cyc(1);
    endtask : wr
    task automatic rd(logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'h1;
        cyc(1);
        reg_rd <= 1'h0;
        @(negedge ref_clk);
        d = reg_rdata;
        @(posedge ref_clk);
    endtask : rd
    task automatic pin(int p, logic lvl);
        if (p) ext_irq_pin_one <= lvl;
        else ext_irq_pin_zero <= lvl;
    endtask : pin
    task automatic ack_all;
        auto_ack <= 1'h1;
        cyc(3);
        auto_ack <= 1'h0;
    endtask : ack_all
    task automatic doze(logic [7:0] c, logic halt);
        wr(8'h01, 8'h00);
        wr(8'h00, c);
        wr(8'h01, 8'h01);
        sleep_instr <= 1'h1;
        cyc(1);
        sleep_instr <= 1'h0;
        @(negedge ref_clk);
        chk("halt after sleep", 8'(halt), 8'(cpu_halt));
        @(posedge ref_clk);
    endtask : doze
    task automatic wait_awake(int n);
        int i, t = sleep_wake_pkg::RESET_DELAY_CYCLES;
        for (i = 0; i < n && cpu_halt !== 1'h0; i++) @(negedge ref_clk);
        chk("awake", 8'h00, 8'(cpu_halt));
        chk("startup length", 8'h01, 8'(i > t && i < t + 5));
        @(posedge ref_clk);
    endtask : wait_awake
    initial begin
        cyc(4000);
        err_count++;
        print_verdict();
    end
    initial begin
        void'($urandom(40588));
        cyc(2);
        rst_n <= 1'h1;
        global_irq_en <= 1'h1;
        cyc(1);
        rd(8'h00);
        chk("control reset", 8'h00, d);
        rd(8'h01);
        chk("mask reset", 8'h00, d);
        v = 8'($urandom) & 8'hcf;
        wr(8'h00, v);
        rd(8'h00);
        chk("control", v & 8'h7f, d);
        wr(8'h02, 8'($urandom));
        rd(8'h02);
        chk("status", {4'h3, v[5:4], 2'h0}, d);
        rd(8'($urandom_range(255, 3)));
        chk("unmapped", 8'h00, d);
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 4; c++) begin
                wr(8'h01, 8'h00);
                wr(8'h00, 8'(c << (2 * p)));
                wr(8'h01, 8'(1 << p));
                pin(p, 1'h0);
                cyc(4);
                @(negedge ref_clk);
                chk("request on fall", 8'(fall_req(c)), 8'(req_of(p)));
                @(posedge ref_clk);
                global_irq_en <= 1'h0;
                @(negedge ref_clk);
                chk("request gated", 8'h00, 8'(req_of(p)));
                @(posedge ref_clk);
                global_irq_en <= 1'h1;
                ack_all();
                pin(p, 1'h1);
                cyc(4);
                @(negedge ref_clk);
                chk("request on rise", 8'(c == 3), 8'(req_of(p)));
                @(posedge ref_clk);
                ack_all();
            end
        end
        doze(8'h00, 1'h0);
        doze(8'h50, 1'h0);
        doze(8'h40, 1'h1);
        chk("idle clocks", 8'h01, 8'({main_osc_stop, sync_timers_run}));
        internal_irq_req <= 1'h1;
        cyc(1);
        internal_irq_req <= 1'h0;
        @(negedge ref_clk);
        chk("idle wake", 8'h01, 8'({cpu_halt, wake_resume}));
        @(posedge ref_clk);
        doze(8'h6a, 1'h1);
        chk("oscillator stop", 8'h01, 8'(main_osc_stop));
        pin(0, 1'h0);
        cyc(12);
        chk("edge ignored", 8'h01, 8'(cpu_halt));
        wdt_enable <= 1'h1;
        wdt_timeout <= 1'h1;
        pin(0, 1'h1);
        cyc(1);
        wdt_timeout <= 1'h0;
        wait_awake(sleep_wake_pkg::RESET_DELAY_CYCLES + 20);
        wdt_enable <= 1'h0;
        doze(8'h60, 1'h1);
        pin(0, 1'h0);
        cyc(20);
        pin(0, 1'h1);
        cyc(200);
        chk("short level", 8'h03, 8'({cpu_halt, main_osc_stop}));
        pin(0, 1'h0);
        wait_awake(sleep_wake_pkg::RESET_DELAY_CYCLES + 20);
        pin(0, 1'h1);
        ack_all();
        timer_two_async_sel <= 1'h1;
        doze(8'h7a, 1'h1);
        chk("timer two runs", 8'h03, 8'({timer_two_run, main_osc_stop}));
        if ($urandom_range(1, 0)) timer_two_ovf_irq <= 1'h1;
        else timer_two_cmp_irq <= 1'h1;
        cyc(1);
        timer_two_ovf_irq <= 1'h0;
        timer_two_cmp_irq <= 1'h0;
        wait_awake(sleep_wake_pkg::RESET_DELAY_CYCLES + 20);
        timer_two_async_sel <= 1'h0;
        doze(8'h60, 1'h1);
        ext_reset_pin_n <= 1'h0;
        cyc(4);
        ext_reset_pin_n <= 1'h1;
        cyc(3);
        @(negedge ref_clk);
        chk("reset wake", 8'h01, 8'({cpu_halt, vecs == 1}));
        @(posedge ref_clk);
        rd(8'h00);
        chk("control kept", 8'h60, d);
        print_verdict();
    end
endmodule : tb
